/* File: escc_defines.vh */
// Constants of the emulator setup and switch control block.
`ifndef ESCC_DEFINES_VH
`define ESCC_DEFINES_VH
`define ESCC_ITEM_USER     8'h01
`define ESCC_ITEM_RSTCH    8'h02
`define ESCC_ITEM_FLOW     8'h03
`define ESCC_ITEM_TRACE    8'h04
`define ESCC_ITEM_T_BAUD   8'h0a
`define ESCC_ITEM_T_STOP   8'h0b
`define ESCC_ITEM_T_PAR    8'h0c
`define ESCC_ITEM_T_LINES  8'h0d
`define ESCC_ITEM_T_ESC    8'h0e
`define ESCC_ITEM_C_BAUD   8'h14
`define ESCC_ITEM_C_STOP   8'h15
`define ESCC_ITEM_C_PAR    8'h16
`define ESCC_ITEM_C_ESC    8'h17
`define ESCC_ITEM_TERM     8'h18
`define ESCC_ITEM_RECLEN   8'h19
`define ESCC_ITEM_FORMAT   8'h1a
`define ESCC_ITEM_ACK      8'h1b
`define ESCC_BAUD_MIN      4'h1
`define ESCC_BAUD_DEF      4'he
`define ESCC_STOP_ONE      2'h1
`define ESCC_STOP_TWO      2'h2
`define ESCC_PAR_NONE      2'h0
`define ESCC_PAR_EVEN      2'h1
`define ESCC_PAR_ODD       2'h2
`define ESCC_RST_CH_DEF    7'h1a
`define ESCC_XON_DEF       7'h11
`define ESCC_XOFF_DEF      7'h13
`define ESCC_ESC_DEF       7'h1b
`define ESCC_TERM0_DEF     7'h0d
`define ESCC_TERM12_DEF    7'h00
`define ESCC_ACK_DEF       7'h06
`define ESCC_RECLEN_MIN    7'h01
`define ESCC_RECLEN_DEF    7'h20
`define ESCC_FMT_MAX       3'h5
`define ESCC_FMT_DEF       3'h0
`define ESCC_TRACE_DEF     2'h2
`define ESCC_LINES_DEF     8'h18
`define ESCC_CLK_HZ        10000000
`define ESCC_TO_SHORT      2240
`define ESCC_TO_LONG       35840
`define ESCC_IRQ_DELAY     160
`endif

/* File: escc_baud_gen.v */
// Bit-rate enable generator for one serial port.
`timescale 1ns/1ps
`default_nettype none
`include "escc_defines.vh"
module escc_baud_gen #(
  parameter CLK_HZ = `ESCC_CLK_HZ
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire [3:0] rate_code,
  output reg        bit_tick
);
  // Divisors give a sixteen-times oversampling tick; fractional rates round to nearest.
  function [15:0] escc_div;
    input [3:0] code;
    reg   [31:0] tenth_baud;
    reg   [31:0] ratio;
    begin
      case (code)
        4'h1: tenth_baud = 750;
        4'h2: tenth_baud = 1100;
        4'h3: tenth_baud = 1345;
        4'h4: tenth_baud = 1500;
        4'h5: tenth_baud = 3000;
        4'h6: tenth_baud = 6000;
        4'h7: tenth_baud = 12000;
        4'h8: tenth_baud = 18000;
        4'h9: tenth_baud = 20000;
        4'ha: tenth_baud = 24000;
        4'hb: tenth_baud = 36000;
        4'hc: tenth_baud = 48000;
        4'hd: tenth_baud = 72000;
        4'hf: tenth_baud = 192000;
        default: tenth_baud = 96000;
      endcase
      ratio    = (CLK_HZ * 10 / 16 + tenth_baud / 2) / tenth_baud;
      escc_div = ratio[15:0];
    end
  endfunction
  reg [15:0] count;
  wire [15:0] limit;
  assign limit = escc_div(rate_code);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count    <= 16'h0000;
      bit_tick <= 1'b0;
    end else if (count + 16'h0001 >= limit) begin
      count    <= 16'h0000;
      bit_tick <= 1'b1;
    end else begin
      count    <= count + 16'h0001;
      bit_tick <= 1'b0;
    end
  end
endmodule // escc_baud_gen
`default_nettype wire

/* File: escc_setup.v */
// Setup store, character recogniser and run and paused-bus switch control.
`timescale 1ns/1ps
`default_nettype none
`include "escc_defines.vh"
module escc_setup #(
  parameter TO_SHORT  = `ESCC_TO_SHORT,
  parameter TO_LONG   = `ESCC_TO_LONG,
  parameter IRQ_DELAY = `ESCC_IRQ_DELAY
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        set_we,
  input  wire [7:0]  set_item,
  input  wire [7:0]  set_val0,
  input  wire [7:0]  set_val1,
  input  wire [7:0]  set_val2,
  output reg         set_error,
  output reg         user_sel,
  output reg  [1:0]  trace_mode,
  output reg  [7:0]  page_lines,
  output reg  [6:0]  record_len,
  output reg  [2:0]  record_format,
  output reg  [6:0]  ack_char,
  output reg  [3:0]  term_baud_stored,
  output reg  [1:0]  term_stop_stored,
  output reg  [1:0]  term_par_stored,
  output reg  [3:0]  comp_baud_stored,
  output reg  [1:0]  comp_stop_stored,
  output reg  [1:0]  comp_par_stored,
  output reg  [1:0]  term_stop_active,
  output reg  [1:0]  term_par_active,
  output reg  [1:0]  comp_stop_active,
  output reg  [1:0]  comp_par_active,
  output wire        term_bit_tick,
  output wire        comp_bit_tick,
  input  wire        rx_valid,
  input  wire        rx_from_comp,
  input  wire [7:0]  rx_char,
  input  wire        transparent,
  input  wire        download_active,
  input  wire        record_done,
  input  wire        ctl_is_comp,
  output reg         output_halted,
  output reg         cpu_reset_req,
  output reg         transparent_exit,
  output reg         command_end,
  output reg         ack_send,
  output wire        tx_to_term,
  output wire        tx_to_comp,
  input  wire        bus_timeout_switch,
  input  wire        short_timeout_switch,
  input  wire        cache_inhibit_switch,
  input  wire        dual_port_echo_switch,
  input  wire        immediate_irq_switch,
  input  wire        delayed_irq_switch,
  input  wire        address_float_switch,
  input  wire        strobe_hold_switch,
  input  wire        run_mode,
  input  wire        run_start,
  input  wire        paused_access,
  input  wire        cycle_active,
  input  wire        cycle_done,
  input  wire        target_strobe,
  input  wire        target_cache_inhibit,
  output reg         bus_error,
  output reg         emul_stop,
  output wire        strobe_out,
  output wire        cache_inhibit_pin,
  output wire        addr_oe,
  output reg         irq_enable
);
  reg  [6:0]  rst_char;
  reg  [6:0]  xon_char;
  reg  [6:0]  xoff_char;
  reg  [6:0]  t_esc0;
  reg  [6:0]  t_esc1;
  reg  [6:0]  c_esc0;
  reg  [6:0]  c_esc1;
  reg  [6:0]  term0;
  reg  [6:0]  term1;
  reg  [6:0]  term2;
  reg  [3:0]  term_baud_active;
  reg  [3:0]  comp_baud_active;
  reg         t_esc_seen;
  reg         c_esc_seen;
  reg  [1:0]  term_hits;
  reg  [15:0] to_count;
  reg  [7:0]  irq_count;
  reg         irq_pending;
  wire [6:0]  ch;
  wire        to_armed;
  wire [15:0] to_limit;

  localparam [15:0] TO_SHORT_W  = TO_SHORT[15:0];
  localparam [15:0] TO_LONG_W   = TO_LONG[15:0];
  localparam [7:0]  IRQ_DELAY_W = IRQ_DELAY[7:0];

  function escc_legal_sp;
    input [7:0] v;
    begin
      escc_legal_sp = (v == 8'h01) || (v == 8'h02);
    end
  endfunction

  function escc_legal_par;
    input [7:0] v;
    begin
      escc_legal_par = (v <= 8'h02);
    end
  endfunction

  function escc_legal_chr;
    input [7:0] v;
    begin
      escc_legal_chr = ~v[7];
    end
  endfunction

  assign ch = rx_char[6:0];

  // Active line settings are caught only from reset; the reset itself loads the defaults
  // because stored values are constants under asynchronous reset. A soft reset request
  // below copies stored values to the active copies.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      set_error        <= 1'b0;
      user_sel         <= 1'b0;
      trace_mode       <= `ESCC_TRACE_DEF;
      page_lines       <= `ESCC_LINES_DEF;
      record_len       <= `ESCC_RECLEN_DEF;
      record_format    <= `ESCC_FMT_DEF;
      ack_char         <= `ESCC_ACK_DEF;
      rst_char         <= `ESCC_RST_CH_DEF;
      xon_char         <= `ESCC_XON_DEF;
      xoff_char        <= `ESCC_XOFF_DEF;
      t_esc0           <= `ESCC_ESC_DEF;
      t_esc1           <= `ESCC_ESC_DEF;
      c_esc0           <= `ESCC_ESC_DEF;
      c_esc1           <= `ESCC_ESC_DEF;
      term0            <= `ESCC_TERM0_DEF;
      term1            <= `ESCC_TERM12_DEF;
      term2            <= `ESCC_TERM12_DEF;
      term_baud_stored <= `ESCC_BAUD_DEF;
      term_stop_stored <= `ESCC_STOP_ONE;
      term_par_stored  <= `ESCC_PAR_NONE;
      comp_baud_stored <= `ESCC_BAUD_DEF;
      comp_stop_stored <= `ESCC_STOP_ONE;
      comp_par_stored  <= `ESCC_PAR_NONE;
    end else begin
      set_error <= 1'b0;
      if (set_we) begin
        case (set_item)
          `ESCC_ITEM_USER:
            if (set_val0 <= 8'h01) user_sel <= set_val0[0];
            else set_error <= 1'b1;
          `ESCC_ITEM_RSTCH:
            if (escc_legal_chr(set_val0)) rst_char <= set_val0[6:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_FLOW:
            if (escc_legal_chr(set_val0) && escc_legal_chr(set_val1)) begin
              xon_char  <= set_val0[6:0];
              xoff_char <= set_val1[6:0];
            end else set_error <= 1'b1;
          `ESCC_ITEM_TRACE:
            if (set_val0 <= 8'h03) trace_mode <= set_val0[1:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_T_BAUD:
            if (set_val0 >= 8'h01 && set_val0 <= 8'h0f) term_baud_stored <= set_val0[3:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_C_BAUD:
            if (set_val0 >= 8'h01 && set_val0 <= 8'h0f) comp_baud_stored <= set_val0[3:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_T_STOP:
            if (escc_legal_sp(set_val0)) term_stop_stored <= set_val0[1:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_C_STOP:
            if (escc_legal_sp(set_val0)) comp_stop_stored <= set_val0[1:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_T_PAR:
            if (escc_legal_par(set_val0)) term_par_stored <= set_val0[1:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_C_PAR:
            if (escc_legal_par(set_val0)) comp_par_stored <= set_val0[1:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_T_LINES:
            if (set_val0 != 8'h00) page_lines <= set_val0;
            else set_error <= 1'b1;
          `ESCC_ITEM_T_ESC:
            if (escc_legal_chr(set_val0) && escc_legal_chr(set_val1)) begin
              t_esc0 <= set_val0[6:0];
              t_esc1 <= set_val1[6:0];
            end else set_error <= 1'b1;
          `ESCC_ITEM_C_ESC:
            if (escc_legal_chr(set_val0) && escc_legal_chr(set_val1)) begin
              c_esc0 <= set_val0[6:0];
              c_esc1 <= set_val1[6:0];
            end else set_error <= 1'b1;
          `ESCC_ITEM_TERM:
            if (escc_legal_chr(set_val0) && escc_legal_chr(set_val1) &&
                escc_legal_chr(set_val2)) begin
              term0 <= set_val0[6:0];
              term1 <= set_val1[6:0];
              term2 <= set_val2[6:0];
            end else set_error <= 1'b1;
          `ESCC_ITEM_RECLEN:
            if (set_val0 >= 8'h01 && set_val0 <= 8'h7f) record_len <= set_val0[6:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_FORMAT:
            if (set_val0 <= 8'h05) record_format <= set_val0[2:0];
            else set_error <= 1'b1;
          `ESCC_ITEM_ACK:
            if (escc_legal_chr(set_val0)) ack_char <= set_val0[6:0];
            else set_error <= 1'b1;
          default: set_error <= 1'b1;
        endcase
      end
    end
  end

  // The line settings in force change only on a reset character, so a new value waits.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      term_baud_active <= `ESCC_BAUD_DEF;
      term_stop_active <= `ESCC_STOP_ONE;
      term_par_active  <= `ESCC_PAR_NONE;
      comp_baud_active <= `ESCC_BAUD_DEF;
      comp_stop_active <= `ESCC_STOP_ONE;
      comp_par_active  <= `ESCC_PAR_NONE;
    end else if (cpu_reset_req) begin
      term_baud_active <= term_baud_stored;
      term_stop_active <= term_stop_stored;
      term_par_active  <= term_par_stored;
      comp_baud_active <= comp_baud_stored;
      comp_stop_active <= comp_stop_stored;
      comp_par_active  <= comp_par_stored;
    end
  end

  escc_baud_gen u_term_baud (
    .mclk      (mclk),
    .rst       (rst),
    .rate_code (term_baud_active),
    .bit_tick  (term_bit_tick)
  );

  escc_baud_gen u_comp_baud (
    .mclk      (mclk),
    .rst       (rst),
    .rate_code (comp_baud_active),
    .bit_tick  (comp_bit_tick)
  );

  // Received character recognition.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      output_halted    <= 1'b0;
      cpu_reset_req    <= 1'b0;
      transparent_exit <= 1'b0;
      command_end      <= 1'b0;
      ack_send         <= 1'b0;
      t_esc_seen       <= 1'b0;
      c_esc_seen       <= 1'b0;
      term_hits        <= 2'h0;
    end else begin
      cpu_reset_req    <= 1'b0;
      transparent_exit <= 1'b0;
      command_end      <= 1'b0;
      ack_send         <= download_active && rx_from_comp && record_done;
      if (rx_valid) begin
        if (ch == xoff_char) output_halted <= 1'b1;
        else if (ch == xon_char) output_halted <= 1'b0;
        if (ch == rst_char) cpu_reset_req <= 1'b1;
        if (!rx_from_comp) begin
          t_esc_seen <= transparent && (ch == t_esc0);
          if (transparent && t_esc_seen && ch == t_esc1) transparent_exit <= 1'b1;
        end else begin
          c_esc_seen <= transparent && (ch == c_esc0);
          if (transparent && c_esc_seen && ch == c_esc1) transparent_exit <= 1'b1;
          // Sequence matcher restarts on its first character; overlap is not tracked.
          if (term_hits == 2'h2 && ch == term2) begin
            command_end <= 1'b1;
            term_hits   <= 2'h0;
          end else if (term_hits == 2'h1 && ch == term1) term_hits <= 2'h2;
          else if (ch == term0) term_hits <= 2'h1;
          else term_hits <= 2'h0;
        end
      end
    end
  end

  assign tx_to_term = dual_port_echo_switch || !ctl_is_comp;
  assign tx_to_comp = dual_port_echo_switch || ctl_is_comp;

  // Bus cycle watchdog.
  assign to_limit = short_timeout_switch ? TO_SHORT_W : TO_LONG_W;
  assign to_armed = bus_timeout_switch || (paused_access && !run_mode);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      to_count  <= 16'h0000;
      bus_error <= 1'b0;
      emul_stop <= 1'b0;
    end else begin
      bus_error <= 1'b0;
      emul_stop <= 1'b0;
      if (!cycle_active || cycle_done) to_count <= 16'h0000;
      else if (to_count + 16'h0001 >= to_limit) begin
        to_count <= 16'h0000;
        if (to_armed) begin
          bus_error <= 1'b1;
          emul_stop <= run_mode;
        end
      end else to_count <= to_count + 16'h0001;
    end
  end

  assign strobe_out = target_strobe && (run_mode || strobe_hold_switch);
  assign cache_inhibit_pin = cache_inhibit_switch || target_cache_inhibit;
  assign addr_oe = run_mode || !address_float_switch;

  // Interrupt enable at run start.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_enable  <= 1'b0;
      irq_pending <= 1'b0;
      irq_count   <= 8'h00;
    end else if (!run_mode) begin
      irq_enable  <= 1'b0;
      irq_pending <= 1'b0;
      irq_count   <= 8'h00;
    end else if (run_start) begin
      irq_enable  <= immediate_irq_switch;
      irq_pending <= !immediate_irq_switch && delayed_irq_switch;
      irq_count   <= 8'h00;
    end else if (irq_pending) begin
      if (irq_count + 8'h01 >= IRQ_DELAY_W) begin
        irq_enable  <= 1'b1;
        irq_pending <= 1'b0;
      end else irq_count <= irq_count + 8'h01;
    end
  end
endmodule // escc_setup
`default_nettype wire

/* File: escc_target_bus.sv */
// Target bus model that ends each bus cycle after a set latency below 8'hff.
`timescale 1ns/1ps
`default_nettype none
module escc_target_bus (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       cycle_active,
  input  wire logic [7:0] lat,
  output var  logic       cycle_done
);
  logic [7:0] cnt;
  // A latency of 8'hff stands for a target that never ends the cycle.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= cycle_active && lat != 8'hff && cnt == lat;
      cnt <= (!cycle_active || cnt == lat) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule // escc_target_bus
`default_nettype wire

/* File: escc_setup_properties.sv */
// Concurrent checks on the ports of the setup and switch control block.
`timescale 1ns/1ps
`default_nettype none
module escc_setup_properties #(
  parameter TO_SHORT  = 2240,
  parameter IRQ_DELAY = 160
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       cpu_reset_req,
  input wire logic [1:0] term_stop_stored,
  input wire logic [1:0] term_stop_active,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic       irq_enable,
  input wire logic       run_start,
  input wire logic       immediate_irq_switch,
  input wire logic       delayed_irq_switch,
  input wire logic       cycle_active,
  input wire logic       cycle_done,
  input wire logic       bus_error,
  input wire logic       bus_timeout_switch,
  input wire logic       short_timeout_switch,
  input wire logic       paused_access,
  input wire logic       cache_inhibit_pin,
  input wire logic       cache_inhibit_switch,
  input wire logic       target_cache_inhibit,
  input wire logic       run_mode,
  input wire logic       addr_oe,
  input wire logic       address_float_switch,
  input wire logic       strobe_out,
  input wire logic       strobe_hold_switch,
  input wire logic       tx_to_comp,
  input wire logic       tx_to_term,
  input wire logic       ctl_is_comp,
  input wire logic       dual_port_echo_switch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  localparam int IRQ_LO = IRQ_DELAY - 4;
  localparam int IRQ_HI = IRQ_DELAY + 4;
  logic [15:0] wait_cnt;
  // Counts how long the open target cycle has waited for its end.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 16'h0000;
    end else begin
      wait_cnt <= (!cycle_active || cycle_done) ? 16'h0000 : wait_cnt + 16'h0001;
    end
  end
  property p_hold; !cpu_reset_req |=> $stable(term_stop_active); endproperty
  a_hold: assert property (p_hold) else $error("active stop bits moved");
  property p_load; cpu_reset_req |=> term_stop_active == $past(term_stop_stored); endproperty
  a_load: assert property (p_load) else $error("stored stop bits not applied");
  property p_rstch; rx_valid && rx_char == 8'h1a |=> cpu_reset_req; endproperty
  a_rstch: assert property (p_rstch) else $error("reset character ignored");
  property p_cache; cache_inhibit_pin == (cache_inhibit_switch || target_cache_inhibit); endproperty
  a_cache: assert property (p_cache) else $error("cache inhibit pin wrong");
  property p_float; !run_mode && !paused_access |-> addr_oe == !address_float_switch; endproperty
  a_float: assert property (p_float) else $error("address drive wrong");
  property p_strobe; !run_mode && !strobe_hold_switch |-> !strobe_out; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe active while paused");
  property p_echo;
    tx_to_comp == (ctl_is_comp || dual_port_echo_switch)
      && tx_to_term == (!ctl_is_comp || dual_port_echo_switch);
  endproperty
  a_echo: assert property (p_echo) else $error("output port routing wrong");
  property p_irq_late;
    run_start && delayed_irq_switch && !immediate_irq_switch
      |=> !irq_enable [*4] ##[IRQ_LO:IRQ_HI] irq_enable;
  endproperty
  a_irq_late: assert property (p_irq_late) else $error("delayed enable off time");
  property p_irq_none; run_start && !delayed_irq_switch && !immediate_irq_switch |=> !irq_enable [*8];
  endproperty
  a_irq_none: assert property (p_irq_none) else $error("interrupts not blocked");
  property p_to_len;
    $rose(bus_error) && short_timeout_switch |-> wait_cnt >= TO_SHORT - 2 && wait_cnt <= TO_SHORT + 3;
  endproperty
  a_to_len: assert property (p_to_len) else $error("short timeout length wrong");
  property p_to_arm; bus_error |-> bus_timeout_switch || paused_access; endproperty
  a_to_arm: assert property (p_to_arm) else $error("bus error while disarmed");
  c_berr: cover property ($rose(bus_error));
  c_rst: cover property (cpu_reset_req);
  c_irq: cover property ($rose(irq_enable));
endmodule // escc_setup_properties
bind escc_setup escc_setup_properties #(.TO_SHORT(TO_SHORT), .IRQ_DELAY(IRQ_DELAY))
  i_escc_setup_properties (
  .mclk, .rst, .cpu_reset_req, .term_stop_stored, .term_stop_active, .rx_valid, .rx_char,
  .irq_enable, .run_start, .immediate_irq_switch, .delayed_irq_switch, .cycle_active, .cycle_done,
  .bus_error, .bus_timeout_switch, .short_timeout_switch, .paused_access, .cache_inhibit_pin,
  .cache_inhibit_switch, .target_cache_inhibit, .run_mode, .addr_oe, .address_float_switch,
  .strobe_out, .strobe_hold_switch, .tx_to_comp, .tx_to_term, .ctl_is_comp, .dual_port_echo_switch);
`default_nettype wire

/* File: test_escc_setup.sv */
// Self-checking bench for the setup and switch control block.
`timescale 1ns/1ps
`default_nettype none
module test_escc_setup;
  localparam [39:0] ITM = 40'h19_1a_04_0d_01;
  localparam [79:0] CV = 80'h80_06_04_00_02_7f_05_03_ff_01;
  logic mclk, rst, set_we, rx_valid, rx_from_comp, transparent, download_active, record_done;
  logic ctl_is_comp, bus_timeout_switch, short_timeout_switch, cache_inhibit_switch;
  logic dual_port_echo_switch, immediate_irq_switch, delayed_irq_switch, address_float_switch;
  logic strobe_hold_switch, run_mode, run_start, paused_access, cycle_active, cycle_done;
  logic target_strobe, target_cache_inhibit, set_error, user_sel, output_halted, cpu_reset_req;
  logic transparent_exit, command_end, ack_send, tx_to_term, tx_to_comp, bus_error, emul_stop;
  logic strobe_out, cache_inhibit_pin, addr_oe, irq_enable, term_bit_tick, comp_bit_tick;
  logic [7:0] set_item, set_val0, set_val1, set_val2, rx_char, page_lines, lat, v;
  logic [6:0] record_len, ack_char;
  logic [3:0] term_baud_stored, comp_baud_stored;
  logic [2:0] record_format;
  logic [1:0] trace_mode, term_stop_stored, term_par_stored, comp_stop_stored, comp_par_stored;
  logic [1:0] term_stop_active, term_par_active, comp_stop_active, comp_par_active;
  logic [7:0] expv [0:4];
  integer seed, miscompares, compares, i, k;
  escc_setup #(.TO_SHORT(20), .TO_LONG(40), .IRQ_DELAY(8)) i_escc_setup (.*);
  escc_target_bus i_escc_target_bus (.mclk, .rst, .cycle_active, .lat, .cycle_done);
  always #50 mclk = ~mclk;
  function logic [7:0] cur(input integer n);
    case (n)
      0: cur = {1'b0, record_len};
      1: cur = {5'h00, record_format};
      2: cur = {6'h00, trace_mode};
      3: cur = page_lines;
      default: cur = {7'h00, user_sel};
    endcase
  endfunction
  function logic ok(input integer n, input logic [7:0] a);
    case (n)
      0: ok = a != 8'h00 && a < 8'h80;
      1: ok = a < 8'h06;
      2: ok = a < 8'h04;
      3: ok = a != 8'h00;
      default: ok = a < 8'h02;
    endcase
  endfunction
  task chk(input logic good);
    begin
      compares = compares + 1;
      if (good !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t ns: mismatch at check %0d", $time, compares);
      end
    end
  endtask
  task wr(input logic [7:0] it, input logic [7:0] a);
    begin
      @(posedge mclk);
      set_we <= 1'b1;
      set_item <= it;
      set_val0 <= a;
      set_val1 <= 8'($random(seed));
      @(posedge mclk);
      set_we <= 1'b0;
      #1;
    end
  endtask
  task rx(input logic p, input logic [7:0] c);
    begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_from_comp <= p;
      rx_char <= c;
      @(posedge mclk);
      rx_valid <= 1'b0;
      #1;
    end
  endtask
  // The first pass only lines up with a tick; the second one measures the spacing.
  task gap(input logic sel, input integer lo, input integer hi);
    integer n, j;
    begin
      for (j = 0; j < 2; j = j + 1) begin
        n = 0;
        do begin
          @(posedge mclk);
          #1 n = n + 1;
        end while ((sel ? comp_bit_tick : term_bit_tick) !== 1'b1 && n < 200);
      end
      chk(n >= lo && n <= hi);
    end
  endtask
  task tmo(input logic [1:0] sw, input integer lo, input integer hi);
    integer n;
    begin
      @(posedge mclk);
      {bus_timeout_switch, short_timeout_switch} <= sw;
      cycle_active <= 1'b1;
      n = 0;
      while (bus_error !== 1'b1 && n < 60) begin
        @(posedge mclk);
        #1 n = n + 1;
      end
      chk(n >= lo && n <= hi && (n == 60 || emul_stop === run_mode));
      @(posedge mclk);
      cycle_active <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task run(input logic [1:0] sw, input integer lo, input integer hi);
    integer n;
    begin
      @(posedge mclk);
      run_mode <= 1'b0;
      {immediate_irq_switch, delayed_irq_switch} <= sw;
      repeat (2) @(posedge mclk);
      run_mode <= 1'b1;
      run_start <= 1'b1;
      @(posedge mclk);
      run_start <= 1'b0;
      #1 n = 0;
      while (irq_enable !== 1'b1 && n < 30) begin
        @(posedge mclk);
        #1 n = n + 1;
      end
      chk(n >= lo && n <= hi);
    end
  endtask
  task summarize;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    seed = 29;
    miscompares = 0;
    compares = 0;
    {set_we, rx_valid, rx_from_comp, transparent, download_active, record_done} = 6'h00;
    {ctl_is_comp, bus_timeout_switch, short_timeout_switch, cache_inhibit_switch} = 4'h0;
    {dual_port_echo_switch, immediate_irq_switch, delayed_irq_switch, address_float_switch} = 4'h0;
    {strobe_hold_switch, run_mode, run_start, paused_access, cycle_active} = 5'h00;
    {target_strobe, target_cache_inhibit, mclk, rst} = 4'h1;
    {set_item, set_val0, set_val1, set_val2, rx_char, lat} = 48'hff;
    {expv[0], expv[1], expv[2], expv[3], expv[4]} = 40'h20_00_02_18_00;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(record_len === 7'h20 && record_format === 3'h0 && trace_mode === 2'h2);
    chk(page_lines === 8'h18 && user_sel === 1'b0 && ack_char === 7'h06);
    chk({term_baud_stored, comp_baud_stored, term_stop_active, term_par_active} === 12'hee4);
    for (i = 0; i < 60; i = i + 1) begin
      k = i < 10 ? i % 5 : {$random(seed)} % 5;
      v = i < 10 ? CV[79-8*i -: 8] : 8'($random(seed));
      if (i >= 10 && i[0])
        v = v & 8'h07;
      wr(ITM[39-8*k -: 8], v);
      chk(set_error === !ok(k, v));
      if (ok(k, v))
        expv[k] = v;
      chk(cur(k) === expv[k]);
    end
    wr(8'h1b, 8'h86);
    chk(set_error === 1'b1 && ack_char === 7'h06);
    wr(8'h1b, 8'h7e);
    chk(set_error === 1'b0 && ack_char === 7'h7e);
    gap(1'b0, 65, 66);
    wr(8'h0b, 8'h02);
    wr(8'h0c, 8'h02);
    wr(8'h0a, 8'h0f);
    wr(8'h16, 8'h01);
    wr(8'h15, 8'h03);
    chk(set_error === 1'b1 && comp_stop_stored === 2'h1);
    wr(8'h14, 8'h00);
    chk(set_error === 1'b1 && comp_baud_stored === 4'he);
    wr(8'h14, 8'h0f);
    chk({term_stop_stored, term_par_stored, term_baud_stored, comp_par_active} === 10'h2bc);
    chk(comp_par_stored === 2'h1);
    gap(1'b1, 65, 66);
    rx(1'b0, 8'h1a);
    chk(cpu_reset_req === 1'b1);
    @(posedge mclk);
    #1;
    chk({term_stop_active, term_par_active, comp_stop_active, comp_par_active} === 8'ha5);
    gap(1'b0, 32, 33);
    gap(1'b1, 32, 33);
    rx(1'b0, 8'h13);
    chk(output_halted === 1'b1);
    rx(1'b1, 8'h11);
    chk(output_halted === 1'b0);
    @(posedge mclk);
    transparent <= 1'b1;
    rx(1'b0, 8'h1b);
    rx(1'b1, 8'h1b);
    chk(transparent_exit === 1'b0);
    rx(1'b1, 8'h1b);
    chk(transparent_exit === 1'b1);
    rx(1'b1, 8'h0d);
    rx(1'b1, 8'h00);
    rx(1'b1, 8'h00);
    chk(command_end === 1'b1);
    @(posedge mclk);
    download_active <= 1'b1;
    record_done <= 1'b1;
    @(posedge mclk);
    record_done <= 1'b0;
    #1;
    chk(ack_send === 1'b1);
    @(posedge mclk);
    run_mode <= 1'b1;
    tmo(2'h3, 19, 23);
    tmo(2'h2, 39, 43);
    tmo(2'h1, 60, 60);
    run_mode <= 1'b0;
    paused_access <= 1'b1;
    tmo(2'h1, 19, 23);
    lat <= 8'h03;
    tmo(2'h3, 60, 60);
    paused_access <= 1'b0;
    run(2'h2, 0, 0);
    run(2'h3, 0, 0);
    run(2'h1, 6, 10);
    run(2'h0, 30, 30);
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge mclk);
      {cache_inhibit_switch, dual_port_echo_switch, address_float_switch, strobe_hold_switch,
       ctl_is_comp, target_strobe, target_cache_inhibit, run_mode} <= 8'($random(seed));
    end
    repeat (3) @(posedge mclk);
    summarize;
  end
endmodule // test_escc_setup
`default_nettype wire
